// ### rtl/tt2_defines.vh
// register map, field positions and reset values of the timer two block
`ifndef TT2_DEFINES_VH
`define TT2_DEFINES_VH

// register offsets
`define TT2_ADDR_CONTROL 8'hc8
`define TT2_ADDR_MODE 8'hc9
`define TT2_ADDR_CAP_LOW 8'hca
`define TT2_ADDR_CAP_HIGH 8'hcb
`define TT2_ADDR_CNT_LOW 8'hcc
`define TT2_ADDR_CNT_HIGH 8'hcd

// control register fields
`define TT2_CTL_OVERFLOW 7
`define TT2_CTL_EXTERNAL 6
`define TT2_CTL_RX_CLOCK 5
`define TT2_CTL_TX_CLOCK 4
`define TT2_CTL_EXT_ENABLE 3
`define TT2_CTL_RUN 2
`define TT2_CTL_COUNTER 1
`define TT2_CTL_CAPTURE 0

// mode register fields
`define TT2_MOD_OUT_ENABLE 1
`define TT2_MOD_DOWN_ENABLE 0

// reset values and count constants
`define TT2_CONTROL_RESET 8'h00
`define TT2_MODE_RESET 2'h0
`define TT2_COUNT_RESET 16'h0000
`define TT2_BYTE_ZERO 8'h00
`define TT2_COUNT_MAX 16'hffff
`define TT2_COUNT_ONE 16'h0001

// oscillator clocks per machine cycle
`define TT2_MACHINE_DIV 6

`endif

// ### rtl/tt2_sync_edge.v
// two-stage pin synchroniser with sampled falling-edge detection
`timescale 1ns/100ps
module tt2_sync_edge (
  input wire clk_i,
  input wire arst_n_i,
  input wire pin_i,
  input wire sample_i,
  output reg level_o,
  output reg fall_o
);
  reg stage_one;
  reg last_sample;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stage_one <= 1'b1;
      level_o <= 1'b1;
      last_sample <= 1'b1;
      fall_o <= 1'b0;
    end else begin
      stage_one <= pin_i;
      level_o <= stage_one;
      // high at one sample, low at the next gives one pulse
      fall_o <= sample_i & last_sample & ~level_o;
      if (sample_i) begin
        last_sample <= level_o;
      end
    end
  end
endmodule // tt2_sync_edge

// ### rtl/tt2_tick_gen.v
// machine cycle tick generator dividing the oscillator clock
`timescale 1ns/100ps
module tt2_tick_gen #(
  parameter DIV = 6,
  parameter W = 3
) (
  input wire clk_i,
  input wire arst_n_i,
  output reg tick_o
);
  localparam integer LAST_INT = DIV - 1;
  localparam [W-1:0] LAST = LAST_INT[W-1:0];
  localparam [W-1:0] ZERO = {W{1'b0}};
  localparam [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};
  reg [W-1:0] phase;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase <= ZERO;
      tick_o <= 1'b0;
    end else begin
      tick_o <= (phase == LAST);
      if (phase == LAST) begin
        phase <= ZERO;
      end else begin
        phase <= phase + ONE;
      end
    end
  end
endmodule // tt2_tick_gen

// ### rtl/tt2_top.v
// timer two: capture, auto-reload, clock-out and baud generator timer/counter
// Behaviour
// R01: mode is off, baud, capture, clock-out or auto-reload, in that priority
// R02: overflow flag set on overflow, never cleared by hardware, not in baud or clock-out
// R03: external flag set on trigger falling edge in capture, reload or baud modes (not in up/down reload, where it toggles on overflow or underflow)
// R04: interrupt requested when enabled and either flag is set
// R05: receive clock select routes this timer's overflows to the serial receiver
// R06: transmit clock select routes this timer's overflows to the serial transmitter
// R07: external enable lets trigger edges capture or reload, never while baud clocking
// R08: counting happens only while run control is one
// R09: timer counts oscillator over six, counter counts count pin falling edges (the timer counts every oscillator clock in baud and clock-out)
// R10: capture select picks capture or reload; serial clocking forces reload on overflow
// R11: software writes zeros to the six reserved mode register bits
// R12: output enable drives the generated clock on the count pin in clock-out mode only
// R13: down-count enable allows up/down counting
// R14: capture mode without external enable is a plain 16-bit timer or counter
// R15: capture copies low count byte to low capture and high to high capture
// R16: capture mode never reloads; counting continues through captures
// R17: software services a capture before the next trigger edge overwrites it
// R18: trigger edge needs high sample, low sample, then flag set on third cycle
// R19: reload with down counting counts up on trigger high, down on low
// R20: overflow is the roll from all ones to zero, one count event wide
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
`include "tt2_defines.vh"
module tt2_top (
  input wire clk_i,
  input wire arst_n_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire irq_enable_i,
  output reg irq_o,
  input wire trigger_input_i,
  input wire count_input_pin_i,
  output reg count_pin_o,
  output reg count_pin_oe_o,
  input wire timer_one_overflow_i,
  output reg rx_clock_tick_o,
  output reg tx_clock_tick_o
);
  localparam [2:0] MODE_OFF = 3'h0;
  localparam [2:0] MODE_RELOAD = 3'h1;
  localparam [2:0] MODE_CAPTURE = 3'h2;
  localparam [2:0] MODE_CLKOUT = 3'h3;
  localparam [2:0] MODE_BAUD = 3'h4;

  // control register state
  reg overflow_flag;
  reg external_flag;
  reg receive_clock_select;
  reg transmit_clock_select;
  reg external_enable;
  reg run_control;
  reg counter_select;
  reg capture_reload_select;
  // mode register state
  reg clock_output_enable;
  reg down_count_enable;
  // count and capture registers
  reg [15:0] count;
  reg [15:0] capture;

  reg [2:0] mode;
  wire machine_tick;
  wire trig_level;
  wire trig_fall;
  wire pin_level;
  wire pin_fall;

  tt2_tick_gen #(
    .DIV(`TT2_MACHINE_DIV),
    .W(3)
  ) u_tick (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .tick_o(machine_tick)
  );

  // trigger sampled once per machine cycle
  tt2_sync_edge u_trig (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .pin_i(trigger_input_i),
    .sample_i(machine_tick), // R18
    .level_o(trig_level),
    .fall_o(trig_fall)
  );

  tt2_sync_edge u_pin (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .pin_i(count_input_pin_i),
    .sample_i(1'b1),
    .level_o(pin_level),
    .fall_o(pin_fall)
  );

  wire serial_clocking = receive_clock_select | transmit_clock_select;

  always @* begin
    if (!run_control) begin
      mode = MODE_OFF; // R01
    end else if (serial_clocking) begin
      mode = MODE_BAUD; // R01
    end else if (capture_reload_select) begin
      mode = MODE_CAPTURE; // R01 R10
    end else if (clock_output_enable) begin
      mode = MODE_CLKOUT; // R01
    end else begin
      mode = MODE_RELOAD; // R01 R10
    end
  end

  // count event source
  reg count_event;
  always @* begin
    count_event = 1'b0;
    if (mode != MODE_OFF) begin // R08
      if (counter_select) begin
        count_event = pin_fall; // R09
      end else if (mode == MODE_BAUD || mode == MODE_CLKOUT) begin
        count_event = 1'b1;
      end else begin
        count_event = machine_tick; // R09
      end
    end
  end

  // direction follows the synchronised trigger level, reload mode only
  wire count_down = (mode == MODE_RELOAD) & down_count_enable & ~trig_level; // R13 R19
  wire overflow = count_event & ~count_down & (count == `TT2_COUNT_MAX); // R20
  wire underflow = count_event & count_down & (count == capture); // R19
  wire trig_active = external_enable & trig_fall; // R07
  wire capture_hit = (mode == MODE_CAPTURE) & trig_active; // R15 R17
  wire trig_reload = (mode == MODE_RELOAD) & ~down_count_enable & trig_active; // R07 R10
  wire flag_mode = (mode == MODE_CAPTURE) | (mode == MODE_RELOAD);
  wire set_overflow = flag_mode & (overflow | underflow); // R02 R14
  wire ext_mode = flag_mode | (mode == MODE_BAUD);
  // in up/down reload the external flag is a toggle bit, so edges do not set it
  wire updown_reload = (mode == MODE_RELOAD) & down_count_enable;
  wire set_external = ext_mode & trig_active & ~updown_reload; // R03
  wire toggle_external = updown_reload & (overflow | underflow); // R19

  // register write decode, exact address match
  wire wr_control = wr_i & (addr_i == `TT2_ADDR_CONTROL);
  wire wr_mode = wr_i & (addr_i == `TT2_ADDR_MODE);
  wire wr_cap_low = wr_i & (addr_i == `TT2_ADDR_CAP_LOW);
  wire wr_cap_high = wr_i & (addr_i == `TT2_ADDR_CAP_HIGH);
  wire wr_cnt_low = wr_i & (addr_i == `TT2_ADDR_CNT_LOW);
  wire wr_cnt_high = wr_i & (addr_i == `TT2_ADDR_CNT_HIGH);

  // next count value; capture mode rolls through zero, other modes reload
  // software byte writes win over a same-cycle reload or count
  reg [15:0] next_count;
  always @* begin
    next_count = count;
    if (wr_cnt_low) begin
      next_count = {count[15:8], wdata_i};
    end else if (wr_cnt_high) begin
      next_count = {wdata_i, count[7:0]};
    end else if (overflow && mode != MODE_CAPTURE) begin
      next_count = capture; // R10
    end else if (underflow) begin
      next_count = `TT2_COUNT_MAX; // R19
    end else if (trig_reload) begin
      next_count = capture; // R07 R10
    end else if (count_event && count_down) begin
      next_count = count - `TT2_COUNT_ONE; // R19
    end else if (count_event) begin
      next_count = count + `TT2_COUNT_ONE; // R16 R20
    end
  end

  // a capture edge wins over a software write to the capture bytes
  reg [15:0] next_capture;
  always @* begin
    next_capture = capture;
    if (capture_hit) begin
      next_capture = count; // R15 R16
    end else if (wr_cap_low) begin
      next_capture = {capture[15:8], wdata_i};
    end else if (wr_cap_high) begin
      next_capture = {wdata_i, capture[7:0]};
    end
  end

  // flags: hardware set wins over a software clear in the same cycle
  reg next_overflow_flag;
  reg next_external_flag;
  always @* begin
    next_overflow_flag = wr_control ? wdata_i[`TT2_CTL_OVERFLOW] : overflow_flag;
    next_external_flag = wr_control ? wdata_i[`TT2_CTL_EXTERNAL] : external_flag;
    if (set_overflow) begin
      next_overflow_flag = 1'b1; // R02
    end
    if (set_external) begin
      next_external_flag = 1'b1; // R03
    end else if (toggle_external) begin
      next_external_flag = ~external_flag; // R19
    end
  end

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      overflow_flag <= 1'b0;
      external_flag <= 1'b0;
      receive_clock_select <= 1'b0;
      transmit_clock_select <= 1'b0;
      external_enable <= 1'b0;
      run_control <= 1'b0;
      counter_select <= 1'b0;
      capture_reload_select <= 1'b0;
      clock_output_enable <= 1'b0;
      down_count_enable <= 1'b0;
      count <= `TT2_COUNT_RESET;
      capture <= `TT2_COUNT_RESET;
    end else begin
      overflow_flag <= next_overflow_flag;
      external_flag <= next_external_flag;
      count <= next_count;
      capture <= next_capture;
      if (wr_control) begin
        receive_clock_select <= wdata_i[`TT2_CTL_RX_CLOCK];
        transmit_clock_select <= wdata_i[`TT2_CTL_TX_CLOCK];
        external_enable <= wdata_i[`TT2_CTL_EXT_ENABLE];
        run_control <= wdata_i[`TT2_CTL_RUN];
        counter_select <= wdata_i[`TT2_CTL_COUNTER];
        capture_reload_select <= wdata_i[`TT2_CTL_CAPTURE];
      end
      if (wr_mode) begin
        // reserved upper bits are not stored
        clock_output_enable <= wdata_i[`TT2_MOD_OUT_ENABLE]; // R11
        down_count_enable <= wdata_i[`TT2_MOD_DOWN_ENABLE];
      end
    end
  end

  // serial clock ticks come from this timer only while its select bit is set
  wire next_rx_tick = receive_clock_select ? overflow : timer_one_overflow_i; // R05
  wire next_tx_tick = transmit_clock_select ? overflow : timer_one_overflow_i; // R06

  // clock-out level toggles on each overflow and is parked low outside clock-out
  reg next_count_pin;
  always @* begin
    next_count_pin = 1'b0;
    if (mode == MODE_CLKOUT) begin
      next_count_pin = count_pin_o ^ overflow; // R12
    end
  end

  // outputs towards the interrupt controller, serial port and count pin
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_o <= 1'b0;
      rx_clock_tick_o <= 1'b0;
      tx_clock_tick_o <= 1'b0;
      count_pin_o <= 1'b0;
      count_pin_oe_o <= 1'b0;
    end else begin
      irq_o <= irq_enable_i & (overflow_flag | external_flag); // R04
      rx_clock_tick_o <= next_rx_tick; // R05
      tx_clock_tick_o <= next_tx_tick; // R06
      count_pin_oe_o <= (mode == MODE_CLKOUT); // R12
      count_pin_o <= next_count_pin; // R12
    end
  end

  // read mux; data stand for the one cycle after the strobe, zero otherwise
  reg [7:0] next_rdata;
  always @* begin
    next_rdata = `TT2_BYTE_ZERO;
    if (!rd_i) begin
      next_rdata = `TT2_BYTE_ZERO;
    end else if (addr_i == `TT2_ADDR_CONTROL) begin
      next_rdata = {overflow_flag, external_flag, receive_clock_select, transmit_clock_select,
        external_enable, run_control, counter_select, capture_reload_select};
    end else if (addr_i == `TT2_ADDR_MODE) begin
      next_rdata = {6'h00, clock_output_enable, down_count_enable};
    end else if (addr_i == `TT2_ADDR_CAP_LOW) begin
      next_rdata = capture[7:0];
    end else if (addr_i == `TT2_ADDR_CAP_HIGH) begin
      next_rdata = capture[15:8];
    end else if (addr_i == `TT2_ADDR_CNT_LOW) begin
      next_rdata = count[7:0];
    end else if (addr_i == `TT2_ADDR_CNT_HIGH) begin
      next_rdata = count[15:8];
    end
  end

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= `TT2_BYTE_ZERO;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  wire unused_pin_level = pin_level;
endmodule // tt2_top

// ### verification/tt2_monitor.sv
// port-level checker for the timer two block
`timescale 1ns/100ps
module tt2_monitor (
  input wire clk_i,
  input wire arst_n_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire irq_enable_i,
  input wire irq_o,
  input wire count_pin_o,
  input wire count_pin_oe_o,
  input wire timer_one_overflow_i,
  input wire rx_clock_tick_o,
  input wire tx_clock_tick_o
);
  reg [5:0] ctl;
  reg oe;
  reg [1:0] age;
  wire out_mode = ctl[2] & ~ctl[5] & ~ctl[4] & ~ctl[0] & oe;
  // shadow of software-written control bits; age gives settled outputs time
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctl <= 6'h00;
      oe <= 1'b0;
      age <= 2'h0;
    end else if (wr_i && (addr_i == 8'hc8 || addr_i == 8'hc9)) begin
      age <= 2'h0;
      if (addr_i == 8'hc8) ctl <= wdata_i[5:0];
      else oe <= wdata_i[1];
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  irq_gate_a: assert property (!$past(irq_enable_i) |-> !irq_o)
    else $error("interrupt raised while disabled");
  oe_mode_a: assert property (age == 2'h3 |-> count_pin_oe_o == out_mode)
    else $error("clock-out enable disagrees with mode");
  pin_idle_a: assert property (age == 2'h3 && !out_mode |-> !count_pin_o)
    else $error("count pin driven outside clock-out");
  pin_in_mode_a: assert property ($rose(count_pin_o) |-> count_pin_oe_o)
    else $error("count pin toggled without enable");
  rx_source_a: assert property (age == 2'h3 && !ctl[5]
    |-> rx_clock_tick_o == $past(timer_one_overflow_i))
    else $error("receive tick not from other timer");
  tx_source_a: assert property (age == 2'h3 && !ctl[4]
    |-> tx_clock_tick_o == $past(timer_one_overflow_i))
    else $error("transmit tick not from other timer");
  stop_rx_a: assert property (age == 2'h3 && !ctl[2] && ctl[5] |-> !rx_clock_tick_o)
    else $error("receive tick while stopped");
  stop_tx_a: assert property (age == 2'h3 && !ctl[2] && ctl[4] |-> !tx_clock_tick_o)
    else $error("transmit tick while stopped");
  cover property ($rose(irq_o));
  cover property ($rose(count_pin_o));
  cover property (ctl[5] && rx_clock_tick_o);
endmodule // tt2_monitor

bind tt2_top tt2_monitor tt2_monitor_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .irq_enable_i(irq_enable_i), .irq_o(irq_o),
  .count_pin_o(count_pin_o), .count_pin_oe_o(count_pin_oe_o),
  .timer_one_overflow_i(timer_one_overflow_i), .rx_clock_tick_o(rx_clock_tick_o),
  .tx_clock_tick_o(tx_clock_tick_o));

// ### verification/tt2_pin_model.sv
// model of the trigger and count input pins
`timescale 1ns/100ps
module tt2_pin_model (
  input wire clk_i,
  output logic trig_o,
  output logic cnt_o
);
  initial begin
    trig_o = 1'b1;
    cnt_o = 1'b1;
  end
  // each level held well over a machine cycle so the edge is seen
  task automatic trig_fall();
    repeat (18) @(posedge clk_i);
    trig_o <= 1'b0;
    repeat (18) @(posedge clk_i);
    trig_o <= 1'b1;
  endtask
  task automatic set_trig(input logic lvl);
    @(posedge clk_i);
    trig_o <= lvl;
  endtask
  // edges no faster than oscillator over sixteen
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (8) @(posedge clk_i);
      cnt_o <= 1'b0;
      repeat (8) @(posedge clk_i);
      cnt_o <= 1'b1;
    end
  endtask
endmodule // tt2_pin_model

// ### verification/tt2_tb_top.sv
// self-checking bench for the timer two block
`timescale 1ns/100ps
module tt2_tb_top;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic irq_enable_i = 1'b0;
  logic t1_ovf = 1'b0;
  logic [2:0] ph = 3'h0;
  logic [7:0] rdata_o;
  logic irq_o, pin_o, pin_oe_o, rx_o, tx_o, trig, cnt;
  logic [7:0] v, c;
  int miscompares = 0;
  int n_checks = 0;
  int tnum = 0;
  initial forever #25 clk_i = ~clk_i;
  always @(posedge clk_i) ph <= ph + 3'h1;
  always @(posedge clk_i) t1_ovf <= (ph == 3'h7);
  tt2_top tt2_top_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_enable_i(irq_enable_i), .irq_o(irq_o),
    .trigger_input_i(trig), .count_input_pin_i(cnt), .count_pin_o(pin_o),
    .count_pin_oe_o(pin_oe_o), .timer_one_overflow_i(t1_ovf), .rx_clock_tick_o(rx_o),
    .tx_clock_tick_o(tx_o));
  tt2_pin_model tt2_pin_model_i (.clk_i(clk_i), .trig_o(trig), .cnt_o(cnt));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(v, e);
  endtask
  // k selects the awaited signal: interrupt, receive tick or count pin
  task automatic w(input int k);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(posedge clk_i);
      #1;
      if ((k == 0 && irq_o === 1'b1) || (k == 1 && rx_o === 1'b1)) break;
      if (k == 2 && pin_o === 1'b1) break;
    end
    if (i == 3000) begin
      miscompares++;
      wrap_up();
    end
  endtask
  task automatic endt();
    tnum++;
    $display("test %0d done", tnum);
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    arst_n_i <= 1'b1;
    irq_enable_i <= 1'b1;
    rc(8'hc8, 8'h00);
    rc(8'hc9, 8'h00);
    wr(8'hc7, 8'h5a);
    rc(8'hc7, 8'h00);
    wr(8'hc9, 8'h03);
    rc(8'hc9, 8'h03);
    wr(8'hc9, 8'h00);
    endt();
    wr(8'hcd, 8'h10);
    wr(8'hcc, 8'h00);
    wr(8'hc8, 8'h0d);
    tt2_pin_model_i.trig_fall();
    w(0);
    rc(8'hc8, 8'h4d);
    @(posedge clk_i);
    irq_enable_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 chk({7'h00, irq_o}, 8'h00);
    @(posedge clk_i);
    irq_enable_i <= 1'b1;
    rc(8'hcb, 8'h10);
    rd(8'hca);
    c = v;
    rd(8'hcc);
    chk({7'h00, v > c}, 8'h01);
    wr(8'hc8, 8'h0d);
    rc(8'hc8, 8'h0d);
    chk({7'h00, irq_o}, 8'h00);
    endt();
    wr(8'hc8, 8'h01);
    wr(8'hcd, 8'hff);
    wr(8'hcc, 8'hf0);
    rc(8'hcc, 8'hf0);
    wr(8'hc8, 8'h05);
    w(0);
    rc(8'hc8, 8'h85);
    rc(8'hcd, 8'h00);
    wr(8'hc8, 8'h05);
    tt2_pin_model_i.trig_fall();
    rc(8'hc8, 8'h05);
    endt();
    wr(8'hc8, 8'h01);
    wr(8'hcc, 8'h00);
    wr(8'hcd, 8'h00);
    wr(8'hc8, 8'h07);
    tt2_pin_model_i.pulses(5);
    rc(8'hcc, 8'h05);
    wr(8'hc8, 8'h00);
    wr(8'hcb, 8'h12);
    wr(8'hca, 8'h34);
    wr(8'hc8, 8'h0c);
    tt2_pin_model_i.trig_fall();
    rc(8'hcd, 8'h12);
    rc(8'hc8, 8'h4c);
    wr(8'hc8, 8'h00);
    wr(8'hcd, 8'hff);
    wr(8'hcc, 8'hf8);
    wr(8'hc8, 8'h04);
    w(0);
    rc(8'hc8, 8'h84);
    rc(8'hcd, 8'h12);
    endt();
    wr(8'hc8, 8'h00);
    wr(8'hc9, 8'h01);
    wr(8'hcd, 8'h01);
    wr(8'hcc, 8'h00);
    tt2_pin_model_i.set_trig(1'b0);
    wr(8'hc8, 8'h04);
    repeat (60) @(posedge clk_i);
    rc(8'hcd, 8'h00);
    rd(8'hcc);
    chk({7'h00, v > 8'he0}, 8'h01);
    tt2_pin_model_i.set_trig(1'b1);
    wr(8'hc9, 8'h00);
    endt();
    wr(8'hc8, 8'h00);
    wr(8'hcb, 8'hff);
    wr(8'hca, 8'hf0);
    wr(8'hcd, 8'hff);
    wr(8'hcc, 8'hf0);
    wr(8'hc8, 8'h34);
    w(1);
    chk({7'h00, tx_o}, 8'h01);
    rc(8'hc8, 8'h34);
    wr(8'hc8, 8'h30);
    rc(8'hc8, 8'h30);
    wr(8'hc9, 8'h02);
    wr(8'hc8, 8'h04);
    w(2);
    chk({7'h00, pin_oe_o}, 8'h01);
    rc(8'hc8, 8'h04);
    endt();
    wrap_up();
  end
endmodule // tt2_tb_top
